/* core/urx_dev.sv */
`timescale 1ns/100ps
// ============================================================
// Receiver end: sampling, two-entry buffer, status and registers
// Functional notes
// - Software reads ninth bit before data byte
// - Data read advances buffer and its flags
// - Receive complete equals buffer holds unread data
// - Receiver disable flushes buffer, clears complete
// - Interrupt while enabled and complete set
// - Handler must read data to clear
// - Error flags stored with their frame
// - Status writes never change error flags
// - Error flags raise no interrupt
// - Frame error means first stop sampled low
// - Only first stop bit is checked
// - Overrun: buffer full, waiting char, new start
// - Overrun flag cleared by reading its frame's data
// - Parity check on enable, odd/even select
// - Parity result stored with frame
// - Parity flag only if checked at reception
// - Receiver disable aborts frame immediately
// - Disabled receiver releases the input pin
// - Software flushes by reading until empty
// - Resync per frame, filter each bit
// - Sixteen or eight samples per bit
// - Start vote on samples 8-10 or 4-6
// - Bit value by majority of centre samples
module urx_dev #(
	parameter int unsigned DEPTH = 2
) (
	input  wire logic                       clk_i,
	input  wire logic                       srst_i,
	urx_if.dev                              link,
	input  wire logic [urx_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [urx_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic [urx_pkg::DATA_W-1:0]      rdata_o,
	input  wire logic                       gie_i,
	output logic                            rx_irq_o,
	output logic                            pin_claim_o
);
	import urx_pkg::*;

	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);

	// ============================================================
	// Registers and internal state
	logic [7:0]       ctrl_b_q, ctrl_c_q, baud_q, rdata_q;
	logic             u2x_q, irq_q, claim_q, par_q, perr_q, wait_v_q, dor_pend_q;
	urx_rx_state_t    state_q;
	logic [4:0]       cnt_q;
	logic [3:0]       bitn_q;
	logic [1:0]       smp_q;
	logic [8:0]       sh_q;
	urx_entry_t       fifo_q [DEPTH];
	logic [PTR_W-1:0] rptr_q;
	logic [CNT_W-1:0] fill_q;
	urx_entry_t       wait_q;
	logic             rxen, pen, tick, vote_now, bit_v, start_ok, done;
	logic             full, has_data, pop, push_wait, push_new, push;
	logic [3:0]       nbits;
	logic [4:0]       ovs, vlast;
	urx_entry_t       new_ent, head;
	logic [PTR_W-1:0] wptr;
	// Oversample tick, halted while the receiver is off
	urx_tick #(.DIV_W(BAUD_W)) u_tick (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.run_i  (rxen),
		.div_i  (baud_q),
		.tick_o (tick)
	);

	// ============================================================
	// Configuration decode
	assign rxen  = ctrl_b_q[CTB_RXEN];
	assign pen   = ctrl_c_q[CTC_PAR_EN];
	assign nbits = urx_nbits({ctrl_b_q[CTB_SIZE2], ctrl_c_q[CTC_SIZE_HI:CTC_SIZE_LO]});
	assign ovs   = u2x_q ? OVS_DOUBLE : OVS_NORMAL;
	assign vlast = u2x_q ? VOTE_DOUBLE : VOTE_NORMAL;

	// Bit decision on the last centre sample
	assign vote_now = tick && (state_q != RX_IDLE) && (cnt_q == vlast);
	assign bit_v    = (smp_q[1] & smp_q[0]) | (smp_q[1] & link.line)
	                | (smp_q[0] & link.line);
	assign start_ok = vote_now && (state_q == RX_START) && !bit_v;
	assign done     = vote_now && (state_q == RX_STOP);

	// ============================================================
	// Frame recovery
	always_ff @(posedge clk_i) begin
		if (srst_i || !rxen) begin
			state_q <= RX_IDLE;
			cnt_q   <= 5'h01;
			bitn_q  <= 4'h0;
		end else if (tick) begin
			if (state_q == RX_IDLE) begin
				if (!link.line) begin
					state_q <= RX_START;
					cnt_q   <= 5'h02;
				end
			end else begin
				cnt_q <= (cnt_q == ovs) ? 5'h01 : cnt_q + 5'h01;
				if (cnt_q == vlast) begin
					case (state_q)
						RX_START: begin
							state_q <= bit_v ? RX_IDLE : RX_DATA;
							bitn_q  <= 4'h0;
						end
						RX_DATA: begin
							bitn_q <= bitn_q + 4'h1;
							if (bitn_q == nbits - 4'h1) begin
								state_q <= pen ? RX_PAR : RX_STOP;
							end
						end
						RX_PAR:  state_q <= RX_STOP;
						default: state_q <= RX_IDLE;
					endcase
				end
			end
		end
	end
	// Sample history for voting
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			smp_q <= 2'h3;
		end else if (tick) begin
			smp_q <= {smp_q[0], link.line};
		end
	end
	// Data shift and parity check
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sh_q   <= 9'h000;
			par_q  <= 1'b0;
			perr_q <= 1'b0;
		end else if (start_ok) begin
			sh_q   <= 9'h000;
			par_q  <= ctrl_c_q[CTC_PAR_ODD];
			perr_q <= 1'b0;
		end else if (vote_now && state_q == RX_DATA) begin
			sh_q  <= {bit_v, sh_q[8:1]};
			par_q <= par_q ^ bit_v;
		end else if (vote_now && state_q == RX_PAR) begin
			perr_q <= pen && (par_q != bit_v);
		end
	end
	// Completed frame as a buffer entry
	always_comb begin
		new_ent      = '0;
		new_ent.data = sh_q >> (4'(NINE_BITS - nbits));
		new_ent.fe   = !bit_v;
		new_ent.dor  = dor_pend_q;
		new_ent.pe   = perr_q;
	end

	// ============================================================
	// Receive buffer
	assign has_data  = (fill_q != '0);
	assign full      = (fill_q == CNT_W'(DEPTH));
	assign pop       = rd_i && (addr_i == ADDR_DATA) && has_data;
	assign push_wait = wait_v_q && !full;
	assign push_new  = done && !full && !wait_v_q;
	assign push      = push_wait || push_new;
	assign wptr      = PTR_W'(rptr_q + PTR_W'(fill_q));
	assign head      = has_data ? fifo_q[rptr_q] : '0;
	// Entry storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			fifo_q[wptr] <= push_wait ? wait_q : new_ent;
		end
	end
	// Pointers and fill level
	always_ff @(posedge clk_i) begin
		if (srst_i || !rxen) begin
			rptr_q <= '0;
			fill_q <= '0;
		end else begin
			if (pop) begin
				rptr_q <= (rptr_q == PTR_W'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
			end
			fill_q <= fill_q + CNT_W'(push) - CNT_W'(pop);
		end
	end
	// Waiting character and overrun tracking
	always_ff @(posedge clk_i) begin
		if (srst_i || !rxen) begin
			wait_v_q   <= 1'b0;
			wait_q     <= '0;
			dor_pend_q <= 1'b0;
		end else begin
			if (push_wait) begin
				wait_v_q <= 1'b0;
			end
			if (done && (full || wait_v_q)) begin
				wait_v_q <= 1'b1;
				wait_q   <= new_ent;
			end
			if (done) begin
				dor_pend_q <= 1'b0;
			end
			if (start_ok && full && wait_v_q) begin
				dor_pend_q <= 1'b1;
				wait_v_q   <= 1'b0;
			end
		end
	end

	// ============================================================
	// Register writes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_b_q <= RST_CTRL_B;
			ctrl_c_q <= RST_CTRL_C;
			baud_q   <= RST_BAUD;
			u2x_q    <= RST_U2X;
		end else if (wr_i) begin
			if (addr_i == ADDR_STAT_A) begin
				u2x_q <= wdata_i[STA_U2X];
			end else if (addr_i == ADDR_CTRL_B) begin
				ctrl_b_q <= wdata_i & CTB_WR_MASK;
			end else if (addr_i == ADDR_CTRL_C) begin
				ctrl_c_q <= wdata_i & CTC_WR_MASK;
			end else if (addr_i == ADDR_BAUD) begin
				baud_q <= wdata_i;
			end
		end
	end
	// Register reads, data one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			rdata_q <= 8'h00;
			if (addr_i == ADDR_STAT_A) begin
				rdata_q[STA_RXC] <= has_data;
				rdata_q[STA_FE]  <= head.fe;
				rdata_q[STA_DOR] <= head.dor;
				rdata_q[STA_UPE] <= head.pe;
				rdata_q[STA_U2X] <= u2x_q;
			end else if (addr_i == ADDR_CTRL_B) begin
				rdata_q          <= ctrl_b_q;
				rdata_q[CTB_RX9] <= head.data[8];
			end else if (addr_i == ADDR_CTRL_C) begin
				rdata_q <= ctrl_c_q;
			end else if (addr_i == ADDR_DATA) begin
				rdata_q <= head.data[7:0];
			end else if (addr_i == ADDR_BAUD) begin
				rdata_q <= baud_q;
			end
		end
	end
	// Interrupt request and pin ownership
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			irq_q   <= 1'b0;
			claim_q <= 1'b0;
		end else begin
			irq_q   <= ctrl_b_q[CTB_RXCIE] && gie_i && has_data;
			claim_q <= rxen;
		end
	end
	assign rdata_o     = rdata_q;
	assign rx_irq_o    = irq_q;
	assign pin_claim_o = claim_q;

endmodule : urx_dev

/* core/urx_tick.sv */
`timescale 1ns/100ps
// ============================================================
// Oversample tick divider: one pulse every div_i+1 clocks
module urx_tick #(
	parameter int unsigned DIV_W = urx_pkg::BAUD_W
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             run_i,
	input  wire logic [DIV_W-1:0] div_i,
	output logic                  tick_o
);
	import urx_pkg::*;

	logic [DIV_W-1:0] cnt_q;
	logic             tick_q;

	// Count up to the divisor, pulse and restart
	always_ff @(posedge clk_i) begin
		if (srst_i || !run_i) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else if (cnt_q >= div_i) begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign tick_o = tick_q;

endmodule : urx_tick

/* core/urx_xmit.sv */
`timescale 1ns/100ps
// ============================================================
// Remote transmitter end: frames words onto the serial line
module urx_xmit (
	input  wire logic                      clk_i,
	input  wire logic                      srst_i,
	urx_if.xmit                            link,
	input  wire logic [8:0]                tx_data_i,
	input  wire logic                      tx_valid_i,
	output logic                           tx_ready_o,
	input  wire logic [2:0]                size_i,
	input  wire logic                      par_en_i,
	input  wire logic                      par_odd_i,
	input  wire logic                      stop2_i,
	input  wire logic                      dbl_i,
	input  wire logic [urx_pkg::BAUD_W-1:0] div_i,
	input  wire logic                      bad_stop_i,
	input  wire logic                      bad_par_i
);
	import urx_pkg::*;

	urx_tx_state_t state_q;
	logic [8:0]    sh_q;
	logic [3:0]    bitn_q;
	logic [3:0]    nbits_q;
	logic [4:0]    cnt_q;
	logic          par_q;
	logic          stop2_q;
	logic          bad_stop_q;
	logic          line_q;
	logic          ready_q;
	logic          tick;
	logic [4:0]    ovs;
	logic          bit_end;

	urx_tick #(.DIV_W(BAUD_W)) u_tick (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.run_i  (1'b1),
		.div_i  (div_i),
		.tick_o (tick)
	);

	assign ovs     = dbl_i ? OVS_DOUBLE : OVS_NORMAL;
	assign bit_end = tick && (cnt_q == ovs);

	// Frame sequencer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= TX_IDLE;
			cnt_q   <= 5'h01;
			bitn_q  <= 4'h0;
		end else begin
			if (tick) begin
				cnt_q <= (cnt_q == ovs) ? 5'h01 : cnt_q + 5'h01;
			end
			case (state_q)
				TX_IDLE: begin
					if (tx_valid_i && ready_q) begin
						state_q <= TX_START;
						cnt_q   <= 5'h01;
					end
				end
				TX_START: begin
					if (bit_end) begin
						state_q <= TX_DATA;
						bitn_q  <= 4'h0;
					end
				end
				TX_DATA: begin
					if (bit_end) begin
						bitn_q <= bitn_q + 4'h1;
						if (bitn_q == nbits_q - 4'h1) begin
							state_q <= par_en_i ? TX_PAR : TX_STOP;
							bitn_q  <= 4'h0;
						end
					end
				end
				TX_PAR: begin
					if (bit_end) begin
						state_q <= TX_STOP;
					end
				end
				default: begin
					if (bit_end) begin
						bitn_q <= bitn_q + 4'h1;
						if (!stop2_q || bitn_q != 4'h0) begin
							state_q <= TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Word capture, shifting and parity accumulation
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sh_q       <= 9'h000;
			nbits_q    <= NINE_BITS;
			par_q      <= 1'b0;
			stop2_q    <= 1'b0;
			bad_stop_q <= 1'b0;
		end else if (state_q == TX_IDLE && tx_valid_i && ready_q) begin
			sh_q       <= tx_data_i;
			nbits_q    <= urx_nbits(size_i);
			par_q      <= par_odd_i ^ bad_par_i;
			stop2_q    <= stop2_i;
			bad_stop_q <= bad_stop_i;
		end else if (state_q == TX_DATA && bit_end) begin
			par_q <= par_q ^ sh_q[0];
			sh_q  <= {1'b0, sh_q[8:1]};
		end
	end

	// Line level and ready, both registered
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			line_q  <= 1'b1;
			ready_q <= 1'b0;
		end else begin
			ready_q <= (state_q == TX_IDLE) && !(tx_valid_i && ready_q);
			case (state_q)
				TX_START: line_q <= 1'b0;
				TX_DATA:  line_q <= sh_q[0];
				TX_PAR:   line_q <= par_q;
				TX_STOP:  line_q <= !(bad_stop_q && bitn_q == 4'h0);
				default:  line_q <= 1'b1;
			endcase
		end
	end

	assign link.line  = line_q;
	assign tx_ready_o = ready_q;

endmodule : urx_xmit

/* pkg/urx_if.sv */
`timescale 1ns/100ps
// ============================================================
// Serial line between remote transmitter and receiver
interface urx_if;
	logic line;
	modport dev   (input  line);
	modport xmit  (output line);
endinterface : urx_if

/* pkg/urx_pkg.sv */
// ============================================================
// Shared constants and types for the serial receive path
package urx_pkg;

	// ============================================================
	// Register port geometry and offsets
	localparam int unsigned ADDR_W       = 3;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned BAUD_W       = 8;
	localparam logic [2:0]  ADDR_STAT_A  = 3'h0;
	localparam logic [2:0]  ADDR_CTRL_B  = 3'h1;
	localparam logic [2:0]  ADDR_CTRL_C  = 3'h2;
	localparam logic [2:0]  ADDR_DATA    = 3'h3;
	localparam logic [2:0]  ADDR_BAUD    = 3'h4;

	// ============================================================
	// Field positions
	localparam int unsigned STA_RXC      = 7;
	localparam int unsigned STA_FE       = 4;
	localparam int unsigned STA_DOR      = 3;
	localparam int unsigned STA_UPE      = 2;
	localparam int unsigned STA_U2X      = 1;
	localparam int unsigned CTB_RXCIE    = 7;
	localparam int unsigned CTB_RXEN     = 4;
	localparam int unsigned CTB_SIZE2    = 2;
	localparam int unsigned CTB_RX9      = 1;
	localparam int unsigned CTB_TX9      = 0;
	localparam int unsigned CTC_PAR_EN   = 5;
	localparam int unsigned CTC_PAR_ODD  = 4;
	localparam int unsigned CTC_STOP2    = 3;
	localparam int unsigned CTC_SIZE_HI  = 2;
	localparam int unsigned CTC_SIZE_LO  = 1;
	localparam logic [7:0]  CTB_WR_MASK  = 8'h95;
	localparam logic [7:0]  CTC_WR_MASK  = 8'h3e;

	// ============================================================
	// Reset values
	localparam logic [7:0]  RST_CTRL_B   = 8'h00;
	localparam logic [7:0]  RST_CTRL_C   = 8'h06;
	localparam logic [7:0]  RST_BAUD     = 8'h33;
	localparam logic        RST_U2X      = 1'b0;

	// ============================================================
	// Oversampling and voting
	localparam logic [4:0]  OVS_NORMAL   = 5'h10;
	localparam logic [4:0]  OVS_DOUBLE   = 5'h08;
	localparam logic [4:0]  VOTE_NORMAL  = 5'h0a;
	localparam logic [4:0]  VOTE_DOUBLE  = 5'h06;
	localparam logic [2:0]  SIZE_NINE    = 3'h7;
	localparam logic [3:0]  SIZE_BASE    = 4'h5;
	localparam logic [3:0]  NINE_BITS    = 4'h9;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} urx_rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} urx_tx_state_t;

	typedef struct packed {
		logic       fe;
		logic       dor;
		logic       pe;
		logic [8:0] data;
	} urx_entry_t;

	// Character size code to number of data bits
	function automatic logic [3:0] urx_nbits(input logic [2:0] size);
		if (size == SIZE_NINE) begin
			return NINE_BITS;
		end
		return SIZE_BASE + {2'h0, size[1:0]};
	endfunction : urx_nbits

endpackage : urx_pkg

/* tb/uart_receive_buffer_status_bench.sv */
`timescale 1ns/100ps
// ============================================================
// Both ends joined; software access through the register port
module uart_receive_buffer_status_bench;
	import urx_pkg::*;
	logic              clk_i      = 1'b0;
	logic              srst_i     = 1'b1;
	logic [ADDR_W-1:0] addr_i     = '0;
	logic [DATA_W-1:0] wdata_i    = '0;
	logic              wr_i       = 1'b0;
	logic              rd_i       = 1'b0;
	logic              gie_i      = 1'b1;
	logic [8:0]        tx_data_i  = '0;
	logic              tx_valid_i = 1'b0;
	logic [2:0]        size_i     = 3'h3;
	logic              par_en_i   = 1'b0;
	logic              par_odd_i  = 1'b0;
	logic              stop2_i    = 1'b0;
	logic              dbl_i      = 1'b0;
	logic              bad_stop_i = 1'b0;
	logic              bad_par_i  = 1'b0;
	logic [DATA_W-1:0] rdata_o;
	logic              rx_irq_o;
	logic              pin_claim_o;
	logic              tx_ready_o;
	logic [7:0]        v;
	int                errors     = 0;
	int                num_checks = 0;
	int                n;
	// Parity/speed rows: ctrl C, status A write, {par_en,odd,bad,dbl}, status
	logic [7:0] cf_c[4] = '{8'h26, 8'h36, 8'h36, 8'h06};
	logic [7:0] cf_s[4] = '{8'h00, 8'h00, 8'h02, 8'h00};
	logic [3:0] cf_x[4] = '{4'ha, 4'hc, 4'hf, 4'h2};
	logic [7:0] cf_e[4] = '{8'h84, 8'h80, 8'h86, 8'h80};

	urx_if lnk ();

	// Clock
	always #5 clk_i = ~clk_i;

	// ============================================================
	// Design ends and checker
	urx_dev i_urx_dev (.clk_i(clk_i), .srst_i(srst_i), .link(lnk), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gie_i(gie_i),
		.rx_irq_o(rx_irq_o), .pin_claim_o(pin_claim_o));
	urx_xmit i_urx_xmit (.clk_i(clk_i), .srst_i(srst_i), .link(lnk), .tx_data_i(tx_data_i),
		.tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .size_i(size_i),
		.par_en_i(par_en_i), .par_odd_i(par_odd_i), .stop2_i(stop2_i), .dbl_i(dbl_i),
		.div_i(8'h03), .bad_stop_i(bad_stop_i), .bad_par_i(bad_par_i));
	urx_sva i_urx_sva (.clk_i(clk_i), .srst_i(srst_i), .line(lnk.line), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gie_i(gie_i),
		.rx_irq_o(rx_irq_o), .pin_claim_o(pin_claim_o));

	// ============================================================
	// Tasks
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rchk

	task automatic wait_ready(input logic lvl);
		int k;
		k = 0;
		while (tx_ready_o !== lvl) begin
			@(posedge clk_i);
			#1;
			k++;
			if (k > 4000) begin
				errors++;
				results();
			end
		end
	endtask : wait_ready

	// Hands one word to the transmitter and waits for its frame to finish
	task automatic send(input logic [8:0] d, input logic bs, input logic bp);
		wait_ready(1'b1);
		@(posedge clk_i);
		tx_data_i  <= d;
		bad_stop_i <= bs;
		bad_par_i  <= bp;
		tx_valid_i <= 1'b1;
		@(posedge clk_i);
		tx_valid_i <= 1'b0;
		#1 wait_ready(1'b1);
		repeat (4) @(posedge clk_i);
	endtask : send

	task automatic pins(input logic irq, input logic claim);
		repeat (2) @(posedge clk_i);
		#1 chk({6'h00, rx_irq_o, pin_claim_o}, {6'h00, irq, claim});
	endtask : pins

	// ============================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		rchk(ADDR_CTRL_B, RST_CTRL_B);
		rchk(ADDR_CTRL_C, RST_CTRL_C);
		rchk(ADDR_BAUD, RST_BAUD);
		rchk(ADDR_STAT_A, 8'h00);
		wr(3'h7, 8'hff);
		rchk(3'h7, 8'h00);
		wr(ADDR_BAUD, 8'h03);
		wr(ADDR_CTRL_B, 8'h90);
		pins(1'b0, 1'b1);
		$display("test reset done");
		send(9'h0a5, 1'b0, 1'b0);
		pins(1'b1, 1'b1);
		rchk(ADDR_STAT_A, 8'h80);
		rchk(ADDR_DATA, 8'ha5);
		rchk(ADDR_STAT_A, 8'h00);
		pins(1'b0, 1'b1);
		@(posedge clk_i);
		gie_i <= 1'b0;
		send(9'h05a, 1'b0, 1'b0);
		pins(1'b0, 1'b1);
		@(posedge clk_i);
		gie_i <= 1'b1;
		pins(1'b1, 1'b1);
		rchk(ADDR_DATA, 8'h5a);
		$display("test complete flag done");
		@(posedge clk_i);
		stop2_i <= 1'b1;
		send(9'h03c, 1'b1, 1'b0);
		send(9'h0c3, 1'b0, 1'b0);
		stop2_i <= 1'b0;
		rchk(ADDR_STAT_A, 8'h90);
		wr(ADDR_STAT_A, 8'h1c);
		rchk(ADDR_STAT_A, 8'h90);
		rchk(ADDR_DATA, 8'h3c);
		rchk(ADDR_STAT_A, 8'h80);
		rchk(ADDR_DATA, 8'hc3);
		$display("test frame error done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL_C, cf_c[i]);
			wr(ADDR_STAT_A, cf_s[i]);
			par_en_i  <= cf_x[i][3];
			par_odd_i <= cf_x[i][2];
			dbl_i     <= cf_x[i][0];
			send(9'h069 + 9'(i), 1'b0, cf_x[i][1]);
			rchk(ADDR_STAT_A, cf_e[i]);
			rchk(ADDR_DATA, 8'h69 + 8'(i));
		end
		wr(ADDR_STAT_A, 8'h00);
		dbl_i <= 1'b0;
		$display("test parity done");
		wr(ADDR_CTRL_B, 8'h94);
		size_i <= SIZE_NINE;
		send(9'h1a5, 1'b0, 1'b0);
		rchk(ADDR_CTRL_B, 8'h96);
		rchk(ADDR_DATA, 8'ha5);
		rchk(ADDR_CTRL_B, 8'h94);
		wr(ADDR_CTRL_B, 8'h90);
		size_i <= 3'h3;
		wr(ADDR_CTRL_C, 8'h00);
		size_i <= 3'h0;
		send(9'h0f5, 1'b0, 1'b0);
		rchk(ADDR_DATA, 8'h15);
		wr(ADDR_CTRL_C, RST_CTRL_C);
		size_i <= 3'h3;
		$display("test ninth bit done");
		for (int i = 1; i < 5; i++) begin
			send(9'(i * 17), 1'b0, 1'b0);
		end
		rchk(ADDR_STAT_A, 8'h80);
		rchk(ADDR_DATA, 8'h11);
		rchk(ADDR_STAT_A, 8'h80);
		rchk(ADDR_DATA, 8'h22);
		rchk(ADDR_STAT_A, 8'h88);
		rchk(ADDR_DATA, 8'h44);
		send(9'h055, 1'b0, 1'b0);
		rchk(ADDR_STAT_A, 8'h80);
		rchk(ADDR_DATA, 8'h55);
		$display("test overrun done");
		send(9'h066, 1'b0, 1'b0);
		send(9'h077, 1'b0, 1'b0);
		n = 0;
		for (int i = 0; i < 5; i++) begin
			rd(ADDR_STAT_A, v);
			if (v[STA_RXC] === 1'b1) begin
				rd(ADDR_DATA, v);
				n++;
			end
		end
		chk(8'(n), 8'h02);
		$display("test flush done");
		send(9'h012, 1'b0, 1'b0);
		wr(ADDR_CTRL_B, 8'h00);
		pins(1'b0, 1'b0);
		wr(ADDR_CTRL_B, 8'h90);
		rchk(ADDR_STAT_A, 8'h00);
		fork
			send(9'h034, 1'b0, 1'b0);
			begin
				repeat (300) @(posedge clk_i);
				wr(ADDR_CTRL_B, 8'h80);
			end
		join
		wr(ADDR_CTRL_B, 8'h90);
		rchk(ADDR_STAT_A, 8'h00);
		send(9'h021, 1'b0, 1'b0);
		rchk(ADDR_DATA, 8'h21);
		$display("test disable done");
		results();
	end
endmodule : uart_receive_buffer_status_bench

/* tb/urx_sva.sv */
`timescale 1ns/100ps
// ============================================================
// Port-level checks across both ends of the serial link
module urx_sva
	import urx_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              line,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic [DATA_W-1:0] rdata_o,
	input  wire logic              gie_i,
	input  wire logic              rx_irq_o,
	input  wire logic              pin_claim_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// Control register B write decode
	wire ctb_wr = wr_i && (addr_i == ADDR_CTRL_B);

	// ============================================================
	// Interrupt request
	property p_gie_gate;
		!gie_i |=> !rx_irq_o;
	endproperty
	a_gie_gate: assert property (p_gie_gate) else $error("request with global enable low");
	property p_ie_off;
		ctb_wr && !wdata_i[CTB_RXCIE] |-> ##2 !rx_irq_o;
	endproperty
	a_ie_off: assert property (p_ie_off) else $error("request with local enable low");
	property p_irq_has_data;
		rd_i && (addr_i == ADDR_STAT_A) |=> (rx_irq_o -> rdata_o[STA_RXC]);
	endproperty
	a_irq_has_data: assert property (p_irq_has_data) else $error("request without data");

	// ============================================================
	// Receiver enable and flush
	property p_dis_flush;
		ctb_wr && !wdata_i[CTB_RXEN] |-> ##2 (!rx_irq_o && !pin_claim_o);
	endproperty
	a_dis_flush: assert property (p_dis_flush) else $error("disable left data or pin");
	property p_en_claim;
		ctb_wr && wdata_i[CTB_RXEN] |-> ##2 pin_claim_o;
	endproperty
	a_en_claim: assert property (p_en_claim) else $error("enable did not claim pin");

	// ============================================================
	// Register port
	property p_rdata_hold;
		!rd_i |=> $stable(rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
	property p_unmapped;
		rd_i && (addr_i > ADDR_BAUD) |=> (rdata_o == 8'h00);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// ============================================================
	// Serial line framing
	property p_start_len;
		$fell(line) |-> !line [*8];
	endproperty
	a_start_len: assert property (p_start_len) else $error("start bit too short");
	property p_idle_rst;
		$fell(srst_i) |-> line;
	endproperty
	a_idle_rst: assert property (p_idle_rst) else $error("line not idle after reset");
endmodule : urx_sva
